// ---- src/rlb_top.sv ----
`timescale 1ns/100ps
module rlb_top
  import rlb_pkg::*;
#(
  parameter int DEPTH = DEPTH_FULL
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              char_clk_in,
  input  wire logic              counter_clear_n_in,
  input  wire logic              row_load_enable_n_in,
  input  wire logic              count_enable_in,
  input  wire logic              output_enable_n_in,
  input  wire logic [DATA_W-1:0] char_data_in,
  output logic      [DATA_W-1:0] char_data_out,
  output logic                   char_data_oe_n_out,
  output logic                   buffer_full_flag_out
);
  localparam int                ADDR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [ADDR_W-1:0] LAST   = ADDR_W'(DEPTH - 1);

  function automatic logic fell(input logic was, input logic now);
    return was & ~now;
  endfunction

  // ---------------- pin synchronisers ----------------
  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] s1_q, s2_q, s3_q, filt_q;
  logic [PIN_W-1:0] s1_d, s2_d, s3_d, filt_d;

  assign pins = {char_data_in, output_enable_n_in, count_enable_in,
                 row_load_enable_n_in, counter_clear_n_in, char_clk_in};

  always_comb begin
    s1_d = pins;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  // a level is accepted only once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_filt
      always_comb begin
        filt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : filt_q[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_q   <= PIN_RST;
      s2_q   <= PIN_RST;
      s3_q   <= PIN_RST;
      filt_q <= PIN_RST;
    end else begin
      s1_q   <= s1_d;
      s2_q   <= s2_d;
      s3_q   <= s3_d;
      filt_q <= filt_d;
    end
  end

  logic              cclk_fall, clr_fall, ce_f, row_load_enable_n_n_f;
  logic [DATA_W-1:0] data_f;

  assign cclk_fall = fell(filt_q[PIN_CCLK], filt_d[PIN_CCLK]);
  assign clr_fall  = fell(filt_q[PIN_CLR_N], filt_d[PIN_CLR_N]);
  assign ce_f      = filt_d[PIN_CE];
  assign row_load_enable_n_n_f  = filt_d[PIN_ROW_LOAD_ENABLE_N_N];
  assign data_f    = filt_d[PIN_DATA_LSB +: DATA_W];

  // ---------------- buffer core ----------------
  logic [DATA_W-1:0] in_q, in_d, wbyte_q, wbyte_d, out_q, out_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic              full_q, full_d, rd_pend_q, rd_pend_d, oe_n_q, oe_n_d;
  logic              ram_we, ram_re, advance;
  logic [DATA_W-1:0] ram_rdata;
  logic [DATA_W-1:0] chk_prev_q, chk_prev_d;
  rlb_op_t           op;

  always_comb begin
    in_d      = in_q;
    wbyte_d   = wbyte_q;
    out_d     = out_q;
    addr_d    = addr_q;
    full_d    = full_q;
    rd_pend_d = 1'b0;
    oe_n_d    = filt_d[PIN_OE_N];
    op        = RLB_OP_HOLD;
    ram_we    = 1'b0;
    ram_re    = 1'b0;
    advance   = 1'b0;
    if (cclk_fall) begin
      in_d = data_f;
    end
    // forward while loading; output lags the write by one character clock
    if (cclk_fall && !row_load_enable_n_n_f) begin
      out_d   = wbyte_q;
      wbyte_d = in_q;
    end
    // clear beats any advance in the same cycle
    if (clr_fall) begin
      addr_d = '0;
      full_d = 1'b0;
    // advance gate; frozen while full; stop on enable low or full
    end else if (cclk_fall && ce_f && !full_q) begin
      op = row_load_enable_n_n_f ? RLB_OP_REPLAY : RLB_OP_LOAD;
    end
    unique case (op)
      // write gate; held byte goes to current address
      RLB_OP_LOAD: begin
        ram_we  = 1'b1;
        advance = 1'b1;
      end
      // read at current address, then step on
      RLB_OP_REPLAY: begin
        ram_re    = 1'b1;
        rd_pend_d = 1'b1;
        advance   = 1'b1;
      end
      RLB_OP_HOLD: begin
      end
      default: begin
      end
    endcase
    // flag raised when the last location is used
    if (advance) begin
      if (addr_q == LAST) begin
        full_d = 1'b1;
      end else begin
        addr_d = addr_q + 1'b1;
      end
    end
    // replay byte arrives two system clocks after the edge, well inside a character time
    if (rd_pend_q) begin
      out_d = ram_rdata;
    end
  end

  // all latches load from the combinational next values
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      in_q      <= '0;
      wbyte_q   <= '0;
      out_q     <= OUT_RST;
      addr_q    <= '0;
      full_q    <= FULL_RST;
      rd_pend_q <= 1'b0;
      oe_n_q    <= OE_N_RST;
    end else begin
      in_q      <= in_d;
      wbyte_q   <= wbyte_d;
      out_q     <= out_d;
      addr_q    <= addr_d;
      full_q    <= full_d;
      rd_pend_q <= rd_pend_d;
      oe_n_q    <= oe_n_d;
    end
  end

  // byte-wide store sized by the depth parameter
  rlb_ram #(
    .DEPTH  (DEPTH),
    .DATA_W (DATA_W),
    .ADDR_W (ADDR_W)
  ) u_ram (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .wr_en_in    (ram_we),
    .wr_addr_in  (addr_q),
    .wr_data_in  (in_q),
    .rd_en_in    (ram_re),
    .rd_addr_in  (addr_q),
    .rd_data_out (ram_rdata)
  );

  assign char_data_out        = out_q;
  // pin enable follows the synchronised output enable
  assign char_data_oe_n_out   = oe_n_q;
  // flag is registered so a chained device sees a clean enable
  assign buffer_full_flag_out = full_q;

  // ---------------- checks ----------------
  // byte forwarded at the last load edge, kept for the lag check
  always_comb begin
    chk_prev_d = chk_prev_q;
    if (cclk_fall && !row_load_enable_n_n_f) begin
      chk_prev_d = in_q;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      chk_prev_q <= '0;
    end else begin
      chk_prev_q <= chk_prev_d;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_replay_req;
    cclk_fall && !clr_fall && ce_f && row_load_enable_n_n_f && !full_q;
  endsequence
  sequence s_load_req;
    cclk_fall && !clr_fall && ce_f && !row_load_enable_n_n_f && !full_q;
  endsequence

  chk_latch_on_fall: assert property (!cclk_fall |=> in_q == $past(in_q))
    else $error("input latch changed without a clock edge");
  chk_count_hold: assert property (!clr_fall && !(cclk_fall && ce_f) |=> addr_q == $past(addr_q))
    else $error("address moved with count enable low");
  chk_pass_through: assert property (cclk_fall && !row_load_enable_n_n_f && !rd_pend_q |=> out_q == $past(chk_prev_q))
    else $error("pass-through byte not one clock late");
  chk_write_gate: assert property (ram_we |-> cclk_fall && ce_f && !row_load_enable_n_n_f && !full_q)
    else $error("RAM written outside load");
  chk_clear_addr: assert property (clr_fall |=> addr_q == '0 && !full_q)
    else $error("clear did not reset counter");
  chk_full_flag: assert property (s_load_req and addr_q == LAST |=> buffer_full_flag_out && addr_q == LAST)
    else $error("overflow flag not raised at last location");
  chk_oe_follow: assert property ($changed(filt_q[PIN_OE_N]) |-> char_data_oe_n_out == filt_q[PIN_OE_N])
    else $error("output enable did not follow pin");
  chk_capture_edge: assert property (cclk_fall |=> in_q == $past(data_f))
    else $error("input byte not captured on edge");
  chk_first_write: assert property (s_load_req and addr_q == '0 |-> ram_we && u_ram.wr_data_in == in_q)
    else $error("first load byte not written at zero");
  chk_replay_seq: assert property (s_replay_req |=> rd_pend_q ##1 out_q == $past(ram_rdata))
    else $error("replay byte not taken from RAM");
  chk_full_hold: assert property (full_q && !clr_fall |=> addr_q == $past(addr_q) && full_q)
    else $error("counter moved while full");
endmodule

// ---- src/rlb_pkg.sv ----
package rlb_pkg;
  localparam int DATA_W        = 8;
  localparam int DEPTH_FULL    = 135;
  localparam int DEPTH_REDUCED = 83;
  localparam int CLK_MHZ       = 125;

  // bit positions inside the vector of synchronised pins
  localparam int PIN_CCLK     = 0;
  localparam int PIN_CLR_N    = 1;
  localparam int PIN_ROW_LOAD_ENABLE_N_N   = 2;
  localparam int PIN_CE       = 3;
  localparam int PIN_OE_N     = 4;
  localparam int PIN_DATA_LSB = 5;
  localparam int PIN_W        = 13;

  // idle levels of the pins: clocks, clears and active-low enables high, count enable and data low
  localparam logic [PIN_W-1:0]  PIN_RST  = 13'h0017;
  localparam logic [DATA_W-1:0] OUT_RST  = 8'h00;
  localparam logic              OE_N_RST = 1'b1;
  localparam logic              FULL_RST = 1'b0;

  typedef enum logic [1:0] {
    RLB_OP_HOLD   = 2'b00,
    RLB_OP_LOAD   = 2'b01,
    RLB_OP_REPLAY = 2'b10
  } rlb_op_t;
endpackage

// ---- src/rlb_ram.sv ----
`timescale 1ns/100ps
module rlb_ram #(
  parameter int DEPTH  = 135,
  parameter int DATA_W = 8,
  parameter int ADDR_W = 8
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              wr_en_in,
  input  wire logic [ADDR_W-1:0] wr_addr_in,
  input  wire logic [DATA_W-1:0] wr_data_in,
  input  wire logic              rd_en_in,
  input  wire logic [ADDR_W-1:0] rd_addr_in,
  output logic      [DATA_W-1:0] rd_data_out
);
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] rd_data_d;

  // array has no reset: contents are only meaningful after a load
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always_comb begin
    rd_data_d = rd_data_out;
    if (rd_en_in) begin
      rd_data_d = mem[rd_addr_in];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= rd_data_d;
    end
  end
endmodule

// ---- tb/rlb_ctl_model.sv ----
`timescale 1ns/100ps
// stands in for the crt timing controller and memory bus
module rlb_ctl_model
  import rlb_pkg::*;
#(
  parameter int HOLD = 5
) (
  input  wire logic              clk_in,
  output logic                   char_clk_out,
  output logic                   clr_n_out,
  output logic                   row_load_n_out,
  output logic                   ce_out,
  output logic                   oe_n_out,
  output logic      [DATA_W-1:0] data_out
);
  // idle levels from time zero so reset release sees no edge
  initial begin
    char_clk_out = 1'b1;
    clr_n_out = 1'b1;
    row_load_n_out = 1'b1;
    ce_out = 1'b0;
    oe_n_out = 1'b1;
    data_out = 8'h00;
  end

  // each pin level lasts HOLD system clocks, above the filter minimum
  task automatic settle();
    repeat (HOLD) @(negedge clk_in);
  endtask

  // row load level driven from the row_load_n argument
  task automatic char_step(input logic [DATA_W-1:0] d, input logic ce, input logic row_load_n);
    data_out = d;
    ce_out = ce;
    row_load_n_out = row_load_n;
    settle();
    char_clk_out = 1'b0;
    settle();
    char_clk_out = 1'b1;
    settle();
  endtask

  task automatic clear_pulse();
    clr_n_out = 1'b0;
    settle();
    clr_n_out = 1'b1;
    settle();
  endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import rlb_pkg::*;
  localparam int DEPTH = 4;
  logic              clk_in = 1'b0;
  logic              rst_in = 1'b1;
  logic              cclk, clr_n, wrn, ce, oe_n, oe_n_o, full;
  logic [DATA_W-1:0] din, dout, dout2;
  int                failures = 0;
  int                check_count = 0;
  logic [DATA_W-1:0] b [6] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3, 8'h0f, 8'hf0};

  initial forever #4 clk_in = ~clk_in;

  rlb_ctl_model PTR (.clk_in(clk_in), .char_clk_out(cclk), .clr_n_out(clr_n), .row_load_n_out(wrn),
                     .ce_out(ce), .oe_n_out(oe_n), .data_out(din));

  rlb_top #(.DEPTH(DEPTH)) DUT (.clk_in(clk_in), .rst_in(rst_in), .char_clk_in(cclk),
    .counter_clear_n_in(clr_n), .row_load_enable_n_in(wrn), .count_enable_in(ce),
    .output_enable_n_in(oe_n), .char_data_in(din), .char_data_out(dout),
    .char_data_oe_n_out(oe_n_o), .buffer_full_flag_out(full));

  // second device counts on the first one's flag
  rlb_top #(.DEPTH(DEPTH)) DUT2 (.clk_in(clk_in), .rst_in(rst_in), .char_clk_in(cclk),
    .counter_clear_n_in(clr_n), .row_load_enable_n_in(wrn), .count_enable_in(full),
    .output_enable_n_in(oe_n), .char_data_in(din), .char_data_out(dout2),
    .char_data_oe_n_out(), .buffer_full_flag_out());

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic test_reset_oe();
    `CHK("oe_n", 1'b1, oe_n_o)
    `CHK("flag", 1'b0, full)
    PTR.oe_n_out = 1'b0;
    PTR.settle();
    `CHK("oe_n", 1'b0, oe_n_o)
    $display("test reset_oe done");
  endtask

  // first edge has count enable low: nothing written, b[0] only captured; the next edge stores it at address 0
  task automatic test_load();
    PTR.clear_pulse();
    PTR.char_step(b[0], 1'b0, 1'b0);
    PTR.char_step(b[1], 1'b1, 1'b0);
    PTR.char_step(b[2], 1'b1, 1'b0);
    `CHK("pass", b[0], dout)
    PTR.char_step(b[3], 1'b1, 1'b0);
    `CHK("pass", b[1], dout)
    `CHK("flag", 1'b0, full)
    PTR.char_step(b[4], 1'b1, 1'b0);
    `CHK("pass", b[2], dout)
    `CHK("flag", 1'b1, full)
    PTR.char_step(b[5], 1'b1, 1'b0);
    `CHK("flag", 1'b1, full)
    $display("test load done");
  endtask

  task automatic test_replay();
    PTR.clear_pulse();
    `CHK("flag", 1'b0, full)
    PTR.char_step(b[5], 1'b1, 1'b1);
    `CHK("replay", b[0], dout)
    PTR.char_step(b[5], 1'b0, 1'b1);
    `CHK("hold", b[0], dout)
    for (int i = 1; i < DEPTH; i++) begin
      PTR.char_step(b[5], 1'b1, 1'b1);
      `CHK("replay", b[i], dout)
    end
    `CHK("flag", 1'b1, full)
    PTR.char_step(b[5], 1'b1, 1'b1);
    `CHK("hold", b[DEPTH-1], dout)
    `CHK("chain", b[DEPTH], dout2)
    PTR.clear_pulse();
    PTR.char_step(b[4], 1'b1, 1'b1);
    `CHK("replay", b[0], dout)
    PTR.char_step(b[4], 1'b1, 1'b1);
    `CHK("replay", b[1], dout)
    $display("test replay done");
  endtask

  task automatic test_release();
    PTR.oe_n_out = 1'b1;
    PTR.settle();
    `CHK("oe_n", 1'b1, oe_n_o)
    $display("test release done");
  endtask

  initial begin
    repeat (20) @(negedge clk_in);
    rst_in = 1'b0;
    @(negedge clk_in);
    test_reset_oe();
    test_load();
    test_replay();
    test_release();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    conclude();
  end
endmodule
